// file: include/pei_mgmt_if.sv
// pei_mgmt_if: register access strobes between frame engine and core
// assumes: rd and wr are one-cycle pulses, rdata answers in the same cycle
`timescale 1ns/100ps
interface pei_mgmt_if;
  logic [4:0] addr;
  logic [15:0] wdata;
  logic wr;
  logic rd;
  logic [15:0] rdata;

  modport eng (output addr, output wdata, output wr, output rd,
               input rdata);
  modport core (input addr, input wdata, input wr, input rd,
                output rdata);
endinterface

// file: include/pei_pkg.sv
// pei_pkg: shared constants of the event-interrupt and false-carrier block
// assumes: 16-bit management registers reached by serial frames on 5-bit
// register addresses, one clock domain
package pei_pkg;

  // ==========================================================================
  // register offsets
  localparam logic [4:0] PEI_OFS_IRQ_CFG = 5'h11;
  localparam logic [4:0] PEI_OFS_GRP_ONE = 5'h12;
  localparam logic [4:0] PEI_OFS_GRP_TWO = 5'h13;
  localparam logic [4:0] PEI_OFS_FC_CNT = 5'h14;

  // ==========================================================================
  // field layout
  localparam int PEI_CFG_OUT_EN_BIT = 0;
  localparam int PEI_CFG_EVT_EN_BIT = 1;
  localparam int PEI_G1_FC_HALF_BIT = 9;
  localparam int PEI_G1_FC_EN_BIT = 1;
  localparam int PEI_G2_FLAG_LSB = 8;
  localparam int PEI_G2_EN_LSB = 0;
  localparam int PEI_NUM_EVT = 8;

  // ==========================================================================
  // reset values and counter limits
  localparam logic [1:0] PEI_CFG_RST = 2'h0;
  localparam logic [7:0] PEI_FLAG_RST = 8'h00;
  localparam logic [7:0] PEI_EN_RST = 8'h00;
  localparam logic [7:0] PEI_FC_RST = 8'h00;
  localparam logic [7:0] PEI_FC_MAX = 8'hff;
  localparam logic [7:0] PEI_FC_HALF = 8'h7f;

  // ==========================================================================
  // serial management frame
  localparam logic [5:0] PEI_PRE_LEN = 6'h20;
  localparam logic [3:0] PEI_HDR_LEN = 4'he;
  localparam logic [3:0] PEI_DATA_LAST = 4'hf;
  localparam logic [1:0] PEI_ST_CODE = 2'h1;
  localparam logic [1:0] PEI_OP_RD = 2'h2;
  localparam logic [1:0] PEI_OP_WR = 2'h1;

  typedef enum logic [1:0] {
    PEI_S_IDLE = 2'b00,
    PEI_S_HDR = 2'b01,
    PEI_S_TA = 2'b11,
    PEI_S_DATA = 2'b10
  } pei_state_t;

endpackage

// file: rtl/pei_event_irq.sv
// pei_event_irq: second event-interrupt group, false-carrier counter and
// the shared interrupt / power-down pin
// assumes: event inputs are one-cycle pulses synchronous to mclk; the
// station manager reaches the registers through the serial frame engine
`timescale 1ns/100ps
module pei_event_irq
  import pei_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic [4:0] phy_addr,
  input wire logic mdc,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe,
  input wire logic eee_error_evt,
  input wire logic an_error_evt,
  input wire logic page_rx_evt,
  input wire logic lb_fifo_evt,
  input wire logic mdix_state,
  input wire logic sleep_evt,
  input wire logic polarity_inv_evt,
  input wire logic wol_packet_evt,
  input wire logic jabber_evt,
  input wire logic false_carrier_evt,
  input wire logic irq_pin_i,
  output logic irq_pin_o,
  output logic irq_pin_oe,
  output logic powerdown_req
);
  import pei_pkg::*;

  pei_mgmt_if mgmt ();

  logic [7:0] flag_q, flag_d;
  logic [7:0] en_q, en_d;
  logic [1:0] cfg_q, cfg_d;
  logic [7:0] fc_q, fc_d;
  logic fc_half_q, fc_half_d;
  logic fc_half_en_q, fc_half_en_d;
  logic mdix_q, mdix_d;
  logic mdix_seen_q, mdix_seen_d;
  logic irq_n_q, irq_n_d;
  logic [7:0] evt;
  logic rd_two, rd_one, rd_fc;
  logic wr_two, wr_one, wr_cfg;
  logic fc_cross;
  logic pending;

  // ==========================================================================
  // register access
  pei_mdio_engine u_engine (
    .mclk(mclk),
    .srst(srst),
    .phy_addr(phy_addr),
    .mdc(mdc),
    .mdio_i(mdio_i),
    .mdio_o(mdio_o),
    .mdio_oe(mdio_oe),
    .bus(mgmt)
  );

  assign rd_two = mgmt.rd && mgmt.addr == PEI_OFS_GRP_TWO;
  assign rd_one = mgmt.rd && mgmt.addr == PEI_OFS_GRP_ONE;
  assign rd_fc = mgmt.rd && mgmt.addr == PEI_OFS_FC_CNT;
  assign wr_two = mgmt.wr && mgmt.addr == PEI_OFS_GRP_TWO;
  assign wr_one = mgmt.wr && mgmt.addr == PEI_OFS_GRP_ONE;
  assign wr_cfg = mgmt.wr && mgmt.addr == PEI_OFS_IRQ_CFG;

  // read data is taken before any clear-on-read takes effect
  always_comb
  begin
    mgmt.rdata = 16'h0000;
    unique case (mgmt.addr)
      PEI_OFS_GRP_TWO:
        mgmt.rdata = {flag_q, en_q};
      PEI_OFS_GRP_ONE:
      begin
        mgmt.rdata[PEI_G1_FC_HALF_BIT] = fc_half_q;
        mgmt.rdata[PEI_G1_FC_EN_BIT] = fc_half_en_q;
      end
      PEI_OFS_FC_CNT:
        mgmt.rdata = {8'h00, fc_q};
      PEI_OFS_IRQ_CFG:
        mgmt.rdata = {14'h0000, cfg_q};
      default:
        mgmt.rdata = 16'h0000;
    endcase
  end

  // ==========================================================================
  // event flags, one latch per bit
  // the crossover flag is derived from a level; the first sample after reset
  // only primes the history so reset itself is not seen as a change
  assign evt[7] = eee_error_evt;
  assign evt[6] = an_error_evt;
  assign evt[5] = page_rx_evt;
  assign evt[4] = lb_fifo_evt;
  assign evt[3] = mdix_seen_q && (mdix_state != mdix_q);
  assign evt[2] = sleep_evt;
  assign evt[1] = polarity_inv_evt | wol_packet_evt;
  assign evt[0] = jabber_evt;

  genvar gi;
  generate
    for (gi = 0; gi < PEI_NUM_EVT; gi++)
    begin : g_flag
      // an event in the cycle of the clearing read is kept
      assign flag_d[gi] = evt[gi] | (flag_q[gi] & ~rd_two);
      assign en_d[gi] = wr_two ? mgmt.wdata[PEI_G2_EN_LSB + gi] :
                        en_q[gi];
    end
  endgenerate

  always_comb
  begin
    mdix_d = mdix_state;
    mdix_seen_d = 1'b1;
    cfg_d = wr_cfg ? mgmt.wdata[1:0] : cfg_q;
    fc_half_en_d = wr_one ? mgmt.wdata[PEI_G1_FC_EN_BIT] : fc_half_en_q;
  end

  // ==========================================================================
  // false-carrier counter
  // a read clears the count; an event in the same cycle counts as one so
  // that it is not lost between two reads
  // a clearing read in the same cycle leaves a count of one, so no step
  // past half full happens then
  assign fc_cross = false_carrier_evt && fc_q == PEI_FC_HALF &&
                    !rd_fc;

  always_comb
  begin
    fc_d = fc_q;
    if (rd_fc)
      fc_d = false_carrier_evt ? 8'h01 : 8'h00;
    else if (false_carrier_evt && fc_q != PEI_FC_MAX)
      fc_d = fc_q + 8'h01;
    fc_half_d = fc_cross | (fc_half_q & ~rd_one);
  end

  // ==========================================================================
  // shared interrupt / power-down pin
  // the pin is driven both ways while it is an output, so no pull-up is
  // needed; as an input a low level requests power-down
  always_comb
  begin
    pending = |(flag_q & en_q) | (fc_half_q & fc_half_en_q);
    irq_n_d = ~(cfg_q[PEI_CFG_EVT_EN_BIT] & pending);
  end

  assign irq_pin_o = irq_n_q;
  assign irq_pin_oe = cfg_q[PEI_CFG_OUT_EN_BIT];
  assign powerdown_req = ~cfg_q[PEI_CFG_OUT_EN_BIT] & ~irq_pin_i;

  // ==========================================================================
  // state registers, one block per group of state
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      flag_q <= PEI_FLAG_RST;
      en_q <= PEI_EN_RST;
      mdix_q <= 1'b0;
      mdix_seen_q <= 1'b0;
    end
    else
    begin
      flag_q <= flag_d;
      en_q <= en_d;
      mdix_q <= mdix_d;
      mdix_seen_q <= mdix_seen_d;
    end
  end

  // config and the half-full enable change only by register writes
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      cfg_q <= PEI_CFG_RST;
      fc_half_en_q <= 1'b0;
    end
    else
    begin
      cfg_q <= cfg_d;
      fc_half_en_q <= fc_half_en_d;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      fc_q <= PEI_FC_RST;
      fc_half_q <= 1'b0;
    end
    else
    begin
      fc_q <= fc_d;
      fc_half_q <= fc_half_d;
    end
  end

  // the pin value is registered so a glitch in the event logic never
  // reaches the board
  always_ff @(posedge mclk)
  begin
    if (srst)
      irq_n_q <= 1'b1;
    else
      irq_n_q <= irq_n_d;
  end

endmodule // pei_event_irq

// file: rtl/pei_mdio_engine.sv
// pei_mdio_engine: serial management frame slave
// assumes: mdc and mdio are sampled as synchronous inputs of mclk, and mdc
// is much slower than mclk
`timescale 1ns/100ps
module pei_mdio_engine
  import pei_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic [4:0] phy_addr,
  input wire logic mdc,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe,
  pei_mgmt_if.eng bus
);
  import pei_pkg::*;

  pei_state_t state_q, state_d;
  logic mdc_q, mdc_d;
  logic [5:0] pre_q, pre_d;
  logic [3:0] cnt_q, cnt_d;
  logic [15:0] sh_q, sh_d;
  logic [13:0] hdr_q, hdr_d;
  logic rd_frame_q, rd_frame_d;
  logic mine_q, mine_d;
  logic o_q, o_d;
  logic oe_q, oe_d;
  logic rise;
  logic [13:0] hdr_nx;

  assign rise = mdc & ~mdc_q;
  assign hdr_nx = {hdr_q[12:0], mdio_i};
  // the read strobe fires while the last address bit is still being
  // shifted in, so the address is taken from the incoming header then
  assign bus.addr = (state_q == PEI_S_HDR) ? hdr_nx[4:0] : hdr_q[4:0];
  assign bus.wdata = sh_q;
  assign mdio_o = o_q;
  assign mdio_oe = oe_q;

  // ==========================================================================
  // frame sequencing
  always_comb
  begin
    state_d = state_q;
    mdc_d = mdc;
    pre_d = pre_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    hdr_d = hdr_q;
    rd_frame_d = rd_frame_q;
    mine_d = mine_q;
    o_d = o_q;
    oe_d = oe_q;
    bus.rd = 1'b0;
    bus.wr = 1'b0;
    if (rise)
    begin
      unique case (state_q)
        PEI_S_IDLE:
        begin
          if (mdio_i)
          begin
            if (pre_q != PEI_PRE_LEN)
              pre_d = pre_q + 6'h01;
          end
          else if (pre_q == PEI_PRE_LEN)
          begin
            state_d = PEI_S_HDR;
            hdr_d = hdr_nx;
            cnt_d = 4'h1;
          end
          else
            pre_d = 6'h00;
        end
        PEI_S_HDR:
        begin
          hdr_d = hdr_nx;
          cnt_d = cnt_q + 4'h1;
          if (cnt_q + 4'h1 == PEI_HDR_LEN)
          begin
            // a frame for another phy is walked through silently
            state_d = PEI_S_TA;
            cnt_d = 4'h0;
            mine_d = hdr_nx[13:12] == PEI_ST_CODE &&
                     hdr_nx[9:5] == phy_addr;
            rd_frame_d = hdr_nx[11:10] == PEI_OP_RD;
            if (mine_d && rd_frame_d)
            begin
              bus.rd = 1'b1;
              sh_d = bus.rdata;
            end
          end
        end
        PEI_S_TA:
        begin
          cnt_d = 4'h1;
          if (cnt_q != 4'h0)
          begin
            state_d = PEI_S_DATA;
            cnt_d = 4'h0;
            if (mine_q && rd_frame_q)
            begin
              o_d = sh_q[15];
              sh_d = {sh_q[14:0], 1'b0};
            end
          end
          else if (mine_q && rd_frame_q)
          begin
            oe_d = 1'b1;
            o_d = 1'b0;
          end
        end
        PEI_S_DATA:
        begin
          cnt_d = cnt_q + 4'h1;
          if (rd_frame_q)
          begin
            o_d = sh_q[15];
            sh_d = {sh_q[14:0], 1'b0};
          end
          else
            sh_d = {sh_q[14:0], mdio_i};
          if (cnt_q == PEI_DATA_LAST)
          begin
            state_d = PEI_S_IDLE;
            pre_d = 6'h00;
            oe_d = 1'b0;
            o_d = 1'b0;
          end
        end
      endcase
    end
    // write lands one cycle after the last data bit is shifted in
    if (state_q == PEI_S_IDLE && state_d == PEI_S_IDLE && mine_q &&
        hdr_q[11:10] == PEI_OP_WR && !rd_frame_q)
    begin
      bus.wr = 1'b1;
      mine_d = 1'b0;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      state_q <= PEI_S_IDLE;
      mdc_q <= 1'b0;
      pre_q <= 6'h00;
      cnt_q <= 4'h0;
      sh_q <= 16'h0000;
      hdr_q <= 14'h0000;
      rd_frame_q <= 1'b0;
      mine_q <= 1'b0;
      o_q <= 1'b0;
      oe_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      mdc_q <= mdc_d;
      pre_q <= pre_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      hdr_q <= hdr_d;
      rd_frame_q <= rd_frame_d;
      mine_q <= (state_q == PEI_S_HDR) ? mine_d :
                ((state_q == PEI_S_IDLE && state_d == PEI_S_HDR) ? 1'b0 :
                mine_d);
      o_q <= o_d;
      oe_q <= oe_d;
    end
  end

endmodule // pei_mdio_engine

// file: sim/pei_event_irq_test.sv
// pei_event_irq_test: self-checking bench of the event-interrupt block
// assumes: pull-ups on mdio and on the shared interrupt pin
`timescale 1ns/100ps
module pei_event_irq_test;
  import pei_pkg::*;
  localparam logic [4:0] PHY = 5'h05;
  localparam int IDX [9] = '{0, 1, 2, 3, 9, 5, 6, 7, 8};
  localparam int BIT [9] = '{15, 14, 13, 12, 11, 10, 9, 9, 8};
  logic mclk, srst, mdio_o, mdio_oe, mdc, mdo, mdo_en, mdix, pd_drv;
  logic irq_pin_o, irq_pin_oe, powerdown_req;
  logic [8:0] evt;
  logic [15:0] rv;
  int err_total = 0;
  int tests_run = 0;
  int cyc = 0;
  wire mdio_in = mdio_oe ? mdio_o : (mdo_en ? mdo : 1'b1);
  wire irq_pin = irq_pin_oe ? irq_pin_o : pd_drv;

  pei_event_irq pei_event_irq_i (
    .mclk(mclk), .srst(srst), .phy_addr(PHY), .mdc(mdc), .mdio_i(mdio_in),
    .mdio_o(mdio_o), .mdio_oe(mdio_oe), .eee_error_evt(evt[0]),
    .an_error_evt(evt[1]), .page_rx_evt(evt[2]), .lb_fifo_evt(evt[3]),
    .mdix_state(mdix), .sleep_evt(evt[5]), .polarity_inv_evt(evt[6]),
    .wol_packet_evt(evt[7]), .jabber_evt(evt[8]),
    .false_carrier_evt(evt[4]), .irq_pin_i(irq_pin),
    .irq_pin_o(irq_pin_o), .irq_pin_oe(irq_pin_oe),
    .powerdown_req(powerdown_req));
  pei_sta_mgr mgr_i (.mclk(mclk), .mdio_in(mdio_in), .mdc(mdc), .mdo(mdo),
    .mdo_en(mdo_en));

  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // a hang costs a mismatch; the full run needs about 31000 cycles
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      err_total = err_total + 1;
      give_verdict();
    end
  end

  // ==========================================================================
  // shared tasks
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rd(input logic [4:0] ra, output logic [15:0] d);
    mgr_i.xfer(PEI_OP_RD, PHY, ra, 16'h0000, d);
  endtask
  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    logic [15:0] x;
    mgr_i.xfer(PEI_OP_WR, PHY, ra, d, x);
  endtask
  // index 9 toggles the crossover level, index 4 is the false carrier
  task automatic pulse(input int k, input int n);
    repeat (n)
    begin
      @(posedge mclk);
      if (k == 9)
        mdix <= ~mdix;
      else
        evt[k] <= 1'b1;
      @(posedge mclk);
      evt <= 9'h000;
    end
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_reset;
    rd(PEI_OFS_GRP_TWO, rv);
    chk("group two", rv, 16'h0000);
    rd(PEI_OFS_FC_CNT, rv);
    chk("count", rv, 16'h0000);
    rd(5'h1f, rv);
    chk("unmapped", rv, 16'h0000);
    $display("test reset values done");
  endtask
  task automatic t_flags;
    for (int k = 0; k < 9; k++)
    begin
      pulse(IDX[k], 1);
      rd(PEI_OFS_GRP_TWO, rv);
      chk("flag", rv, 16'h0001 << BIT[k]);
      rd(PEI_OFS_GRP_TWO, rv);
      chk("flag cleared", rv, 16'h0000);
    end
    $display("test event flags done");
  endtask
  task automatic t_irq;
    wr(PEI_OFS_GRP_TWO, 16'hff80);
    wr(PEI_OFS_IRQ_CFG, 16'h0003);
    chk("pin idle", {14'h0000, irq_pin_oe, irq_pin_o}, 16'h0003);
    pulse(8, 1);
    repeat (4) @(posedge mclk);
    chk("masked", {15'h0000, irq_pin_o}, 16'h0001);
    pulse(0, 1);
    repeat (4) @(posedge mclk);
    chk("irq low", {15'h0000, irq_pin_o}, 16'h0000);
    rd(PEI_OFS_GRP_TWO, rv);
    chk("flags and enables", rv, 16'h8180);
    chk("irq gone", {15'h0000, irq_pin_o}, 16'h0001);
    wr(PEI_OFS_IRQ_CFG, 16'h0000);
    pd_drv <= 1'b0;
    repeat (2) @(posedge mclk);
    chk("pd req", {14'h0000, irq_pin_oe, powerdown_req}, 16'h0001);
    pd_drv <= 1'b1;
    $display("test interrupt pin done");
  endtask
  task automatic t_fc;
    pulse(4, 128);
    rd(PEI_OFS_FC_CNT, rv);
    chk("count", rv, 16'h0080);
    rd(PEI_OFS_GRP_ONE, rv);
    chk("half full", rv, 16'h0200);
    rd(PEI_OFS_FC_CNT, rv);
    chk("count cleared", rv, 16'h0000);
    pulse(4, 127);
    rd(PEI_OFS_GRP_ONE, rv);
    chk("below half", rv, 16'h0000);
    pulse(4, 200);
    rd(PEI_OFS_FC_CNT, rv);
    chk("saturated", rv, 16'h00ff);
    // the crossing in the last run left the half-full flag pending
    wr(PEI_OFS_GRP_ONE, 16'h0002);
    wr(PEI_OFS_IRQ_CFG, 16'h0003);
    chk("half irq", {15'h0000, irq_pin_o}, 16'h0000);
    rd(PEI_OFS_GRP_ONE, rv);
    chk("half and enable", rv, 16'h0202);
    chk("half irq gone", {15'h0000, irq_pin_o}, 16'h0001);
    $display("test false carrier count done");
  endtask

  initial
  begin
    srst = 1'b1;
    evt = 9'h000;
    mdix = 1'b0;
    pd_drv = 1'b1;
    repeat (8) @(posedge mclk);
    srst <= 1'b0;
    t_reset();
    t_flags();
    t_irq();
    t_fc();
    // a second reset in mid-run must bring group-two flags and enables and the count back to zero
    srst <= 1'b1;
    repeat (8) @(posedge mclk);
    srst <= 1'b0;
    t_reset();
    give_verdict();
  end
endmodule // pei_event_irq_test

bind pei_event_irq pei_sva pei_sva_i (
  .mclk(mclk), .srst(srst), .mdc(mdc), .mdio_o(mdio_o), .mdio_oe(mdio_oe),
  .irq_pin_i(irq_pin_i), .irq_pin_o(irq_pin_o), .irq_pin_oe(irq_pin_oe),
  .powerdown_req(powerdown_req));

// file: sim/pei_sta_mgr.sv
// pei_sta_mgr: station manager model sending serial management frames
// assumes: the bench resolves mdio with a pull-up when nobody drives it
`timescale 1ns/100ps
module pei_sta_mgr
  import pei_pkg::*;
(
  input wire logic mclk,
  input wire logic mdio_in,
  output logic mdc,
  output logic mdo,
  output logic mdo_en
);
  initial
  begin
    mdc = 1'b0;
    mdo = 1'b1;
    mdo_en = 1'b0;
  end

  // ==========================================================================
  // one frame; mdc stands low between frames, 13 mclk per bit
  task automatic xfer(input logic [1:0] op, input logic [4:0] phy,
                      input logic [4:0] ra, input logic [15:0] wd,
                      output logic [15:0] rd);
    logic [63:0] f;
    f = {32'hffff_ffff, PEI_ST_CODE, op, phy, ra, 2'h2, wd};
    rd = 16'h0000;
    for (int i = 0; i < 64; i++)
    begin
      @(posedge mclk);
      mdo <= f[63-i];
      // reads release the line from the turnaround on
      mdo_en <= (op == PEI_OP_WR) || (i < 46);
      repeat (6) @(posedge mclk);
      if (i >= 48)
        rd[63-i] = mdio_in;
      mdc <= 1'b1;
      repeat (6) @(posedge mclk);
      mdc <= 1'b0;
    end
    @(posedge mclk);
    mdo_en <= 1'b0;
  endtask
endmodule // pei_sta_mgr

// file: sim/pei_sva.sv
// pei_sva: port-level checks of the event-interrupt block
// assumes: bound to pei_event_irq; mdc half period is above 5 mclk
`timescale 1ns/100ps
module pei_sva
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic mdc,
  input wire logic mdio_o,
  input wire logic mdio_oe,
  input wire logic irq_pin_i,
  input wire logic irq_pin_o,
  input wire logic irq_pin_oe,
  input wire logic powerdown_req
);
  // ==========================================================================
  // helper: cycles since the last mdc edge, and bus activity since reset
  logic mdc_q, mdc_d, act_q, act_d;
  logic [3:0] since_q, since_d;
  always_comb
  begin
    mdc_d = mdc;
    act_d = act_q || (mdc != mdc_q);
    since_d = (since_q == 4'hf) ? since_q : since_q + 4'h1;
    if (mdc != mdc_q)
      since_d = 4'h0;
    if (srst)
    begin
      act_d = 1'b0;
      since_d = 4'hf;
    end
  end
  always_ff @(posedge mclk)
  begin
    mdc_q <= mdc_d;
    act_q <= act_d;
    since_q <= since_d;
  end

  // ==========================================================================
  // assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  a_reset_quiet: assert property (disable iff (1'b0) srst |=>
    !mdio_oe && !irq_pin_oe && irq_pin_o) else $error("pins active in reset");
  a_pd_follows_pin: assert property (powerdown_req ==
    (!irq_pin_oe && !irq_pin_i)) else $error("powerdown request wrong");
  a_mdio_quiet: assert property (since_q > 4'h4 |->
    $stable(mdio_oe) && $stable(mdio_o)) else $error("mdio moved alone");
  a_turn_low: assert property ($rose(mdio_oe) |-> !mdio_o)
    else $error("turnaround bit not low");
  a_oe_word_len: assert property ($fell(mdio_oe) |->
    $past(mdio_oe, 32)) else $error("read word too short");
  a_irq_clear_by_bus: assert property ($rose(irq_pin_o) |->
    since_q < 4'h8) else $error("interrupt cleared without access");
  a_pin_mode_by_bus: assert property ($changed(irq_pin_oe) |->
    since_q < 4'h8) else $error("pin mode changed without access");
  a_idle_no_irq: assert property (!act_q |-> irq_pin_o && !irq_pin_oe)
    else $error("interrupt before any enable");
  cover property ($rose(mdio_oe));
  cover property ($fell(irq_pin_o));
  cover property ($rose(powerdown_req));
endmodule // pei_sva
